// *** logic/gpio_cde_pkg.sv ***
// Register map, field positions and reset values of the port C, D and E block.
package gpio_cde_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] PORT_C_DATA_ADDR = 8'h02;
  localparam logic [7:0] PORT_D_DATA_ADDR = 8'h03;
  localparam logic [7:0] PORT_C_DIR_ADDR  = 8'h06;
  localparam logic [7:0] PORT_D_DIR_ADDR  = 8'h07;
  localparam logic [7:0] PORT_E_DATA_ADDR = 8'h08;
  localparam logic [7:0] PORT_E_DIR_ADDR  = 8'h0C;

  // Implemented bits of each register.
  localparam logic [7:0] PORT_C_DATA_MASK = 8'h3F;
  localparam logic [7:0] PORT_C_DIR_MASK  = 8'hBF;
  localparam logic [7:0] PORT_D_DIR_MASK  = 8'hFB;
  localparam logic [7:0] FULL_MASK        = 8'hFF;
  localparam logic [7:0] DIR_RESET        = 8'h00;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  // Field positions.
  localparam int CLK_OUT_EN_BIT  = 7;
  localparam int CLK_OUT_PIN     = 2;
  localparam int TIMER_CLK_PIN   = 6;
  localparam int SPI_SCK_PIN     = 7;
  localparam int SPI_MOSI_PIN    = 6;
  localparam int SPI_MISO_PIN    = 5;
  localparam int SPI_SS_PIN      = 4;
  localparam int TIMER_CH1_PIN   = 3;
  localparam int TIMER_CH0_PIN   = 2;
  localparam int ASYNC_RX_PIN    = 1;
  localparam int ASYNC_TX_PIN    = 0;

  // ADC channel numbers that land on port D start here.
  localparam logic [4:0] ADC_PORT_D_BASE = 5'h08;
  localparam int         PORT_D_PINS     = 8;

endpackage

// *** logic/gpio_sync2.sv ***
// Two-flop synchroniser for a bus of pin levels.
`timescale 1ns/1ps
module gpio_sync2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** logic/gpio_pin_mux.sv ***
// Per-pin output selection between the general-purpose latch and a peripheral.
`timescale 1ns/1ps
module gpio_pin_mux #(
  parameter int WIDTH = 8
) (
  // Ownership of each pin
  input  wire logic [WIDTH-1:0] periph_own_in,
  // General-purpose drive
  input  wire logic [WIDTH-1:0] latch_in,
  input  wire logic [WIDTH-1:0] dir_in,
  // Peripheral drive
  input  wire logic [WIDTH-1:0] periph_val_in,
  input  wire logic [WIDTH-1:0] periph_oe_in,
  // Resulting drive
  output logic      [WIDTH-1:0] val_out,
  output logic      [WIDTH-1:0] oe_out
);

  assign val_out = (periph_own_in & periph_val_in) | (~periph_own_in & latch_in);
  assign oe_out  = (periph_own_in & periph_oe_in) | (~periph_own_in & dir_in);

endmodule

// *** logic/gpio_ports_c_d_e.sv ***
// Top of the port C, D and E general-purpose I/O block with pin sharing.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module gpio_ports_c_d_e #(
  parameter int PORT_C_W = 6,
  parameter int PORT_D_W = 8,
  parameter int PORT_E_W = 8
) (
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                reset_in,
  // Register port
  input  wire logic [7:0]          addr_in,
  input  wire logic [7:0]          wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [7:0]          rdata_out,
  // Port C pins
  input  wire logic [PORT_C_W-1:0] port_c_pin_in,
  output logic      [PORT_C_W-1:0] port_c_pin_out,
  output logic      [PORT_C_W-1:0] port_c_pin_oe_out,
  // Port D pins
  input  wire logic [PORT_D_W-1:0] port_d_pin_in,
  output logic      [PORT_D_W-1:0] port_d_pin_out,
  output logic      [PORT_D_W-1:0] port_d_pin_oe_out,
  // Port E pins
  input  wire logic [PORT_E_W-1:0] port_e_pin_in,
  output logic      [PORT_E_W-1:0] port_e_pin_out,
  output logic      [PORT_E_W-1:0] port_e_pin_oe_out,
  // ADC and timer controls
  input  wire logic [4:0]          adc_channel_select_in,
  input  wire logic                adc_active_in,
  input  wire logic                timer_ext_clock_sel_in,
  output logic                     timer_ext_clock_out,
  // Timer channels: nonzero edge_level_select hands the pin to the timer
  input  wire logic [1:0]          edge_level_select0_in,
  input  wire logic [1:0]          edge_level_select1_in,
  input  wire logic [1:0]          timer_ch_val_in,
  input  wire logic [1:0]          timer_ch_oe_in,
  // SPI controls and signals
  input  wire logic                serial_periph_enable_in,
  input  wire logic                serial_periph_master_in,
  input  wire logic                mode_fault_enable_in,
  input  wire logic                spi_sck_val_in,
  input  wire logic                spi_mosi_val_in,
  input  wire logic                spi_miso_val_in,
  // Async serial controls and signals
  input  wire logic                async_serial_enable_in,
  input  wire logic                async_tx_val_in,
  // Synchronised pin levels for the sharing peripherals
  output logic      [PORT_E_W-1:0] port_e_sync_out,
  output logic      [PORT_D_W-1:0] port_d_sync_out
);

  // Control registers.
  logic [PORT_C_W-1:0] port_c_latch_q;
  logic [PORT_D_W-1:0] port_d_latch_q;
  logic [PORT_E_W-1:0] port_e_latch_q;
  logic [7:0]          port_c_dir_q;
  logic [PORT_D_W-1:0] port_d_dir_q;
  logic [PORT_E_W-1:0] port_e_dir_q;
  logic [7:0]          rdata_d;

  // Synchronised pins.
  logic [PORT_C_W-1:0] c_sync;
  logic [PORT_D_W-1:0] d_sync;
  logic [PORT_E_W-1:0] e_sync;

  gpio_sync2 #(.WIDTH(PORT_C_W)) u_sync_c (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .async_in (port_c_pin_in),
    .sync_out (c_sync)
  );
  gpio_sync2 #(.WIDTH(PORT_D_W)) u_sync_d (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .async_in (port_d_pin_in),
    .sync_out (d_sync)
  );
  gpio_sync2 #(.WIDTH(PORT_E_W)) u_sync_e (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .async_in (port_e_pin_in),
    .sync_out (e_sync)
  );

  // Address decode.
  wire wr_c_data = wr_in && (addr_in == gpio_cde_pkg::PORT_C_DATA_ADDR);
  wire wr_d_data = wr_in && (addr_in == gpio_cde_pkg::PORT_D_DATA_ADDR);
  wire wr_e_data = wr_in && (addr_in == gpio_cde_pkg::PORT_E_DATA_ADDR);
  wire wr_c_dir  = wr_in && (addr_in == gpio_cde_pkg::PORT_C_DIR_ADDR);
  wire wr_d_dir  = wr_in && (addr_in == gpio_cde_pkg::PORT_D_DIR_ADDR);
  wire wr_e_dir  = wr_in && (addr_in == gpio_cde_pkg::PORT_E_DIR_ADDR);

  // Direction bits as seen by the pins and by the read path.
  wire                clk_out_en = port_c_dir_q[gpio_cde_pkg::CLK_OUT_EN_BIT];
  wire [PORT_C_W-1:0] c_dir      = port_c_dir_q[PORT_C_W-1:0];

  // Function that blends latch and pin per bit by direction.
  function automatic logic [7:0] blend(input logic [7:0] dir, input logic [7:0] latch,
                                       input logic [7:0] pin);
    blend = (dir & latch) | (~dir & pin);
  endfunction

  // Port D analog pins: a selected channel reads as zero on input bits.
  wire [4:0] adc_rel = adc_channel_select_in - gpio_cde_pkg::ADC_PORT_D_BASE;
  wire       adc_on_d = adc_active_in && (adc_channel_select_in >= gpio_cde_pkg::ADC_PORT_D_BASE)
                        && (adc_rel < 5'(gpio_cde_pkg::PORT_D_PINS));
  wire [PORT_D_W-1:0] adc_own = adc_on_d ? (PORT_D_W'(1) << adc_rel[2:0]) : '0;
  wire                timer_clk_own = timer_ext_clock_sel_in;

  // Port D output: bit 2 never drives; analog or timer-clock pins never drive.
  wire [PORT_D_W-1:0] d_free   = ~adc_own & ~(PORT_D_W'(timer_clk_own) << gpio_cde_pkg::TIMER_CLK_PIN);
  wire [PORT_D_W-1:0] d_oe     = port_d_dir_q & d_free;
  wire [PORT_D_W-1:0] d_pinval = d_sync & ~adc_own;
  wire [7:0]          d_read   = blend(port_d_dir_q, port_d_latch_q, d_pinval);

  // Port E ownership.
  wire spi_on   = serial_periph_enable_in;
  wire ss_gp    = !spi_on || (serial_periph_master_in && !mode_fault_enable_in);
  wire tch0_on  = |edge_level_select0_in;
  wire tch1_on  = |edge_level_select1_in;
  wire async_on = async_serial_enable_in;
  wire [PORT_E_W-1:0] e_own = {spi_on, spi_on, spi_on, !ss_gp,
                               tch1_on, tch0_on, async_on, async_on};

  // Peripheral drive for port E: master drives clock and MOSI, slave drives MISO.
  wire master = serial_periph_master_in;
  wire [PORT_E_W-1:0] e_pval = {spi_sck_val_in, spi_mosi_val_in, spi_miso_val_in, 1'b0,
                                timer_ch_val_in[1], timer_ch_val_in[0], 1'b0, async_tx_val_in};
  wire [PORT_E_W-1:0] e_poe  = {master, master, !master, 1'b0,
                                timer_ch_oe_in[1], timer_ch_oe_in[0], 1'b0, 1'b1};
  wire [PORT_E_W-1:0] e_val;
  wire [PORT_E_W-1:0] e_oe;

  gpio_pin_mux #(.WIDTH(PORT_E_W)) u_mux_e (
    .periph_own_in (e_own),
    .latch_in      (port_e_latch_q),
    .dir_in        (port_e_dir_q),
    .periph_val_in (e_pval),
    .periph_oe_in  (e_poe),
    .val_out       (e_val),
    .oe_out        (e_oe)
  );

  // Port C drive: clock output takes pin 2 when enabled.
  wire [PORT_C_W-1:0] c_clk_own = PORT_C_W'(clk_out_en) << gpio_cde_pkg::CLK_OUT_PIN;
  wire [PORT_C_W-1:0] c_oe      = c_dir | c_clk_own;
  // The system clock toggles each edge here; a divided copy stands in for it.
  logic clk_half_q;
  wire [PORT_C_W-1:0] c_val = (port_c_latch_q & ~c_clk_own) |
                              (c_clk_own & {PORT_C_W{clk_half_q}});

  // Read mux; unmapped addresses read zero.
  wire [7:0] c_read = 8'(blend(8'(c_dir), 8'(port_c_latch_q), 8'(c_sync)));
  wire [7:0] e_read = blend(port_e_dir_q, port_e_latch_q, e_sync);
  always_comb begin
    rdata_d = gpio_cde_pkg::READ_ZERO;
    if (rd_in) begin
      unique case (addr_in)
        gpio_cde_pkg::PORT_C_DATA_ADDR: rdata_d = c_read & gpio_cde_pkg::PORT_C_DATA_MASK;
        gpio_cde_pkg::PORT_D_DATA_ADDR: rdata_d = d_read;
        gpio_cde_pkg::PORT_E_DATA_ADDR: rdata_d = e_read;
        gpio_cde_pkg::PORT_C_DIR_ADDR:  rdata_d = port_c_dir_q;
        gpio_cde_pkg::PORT_D_DIR_ADDR:  rdata_d = port_d_dir_q;
        gpio_cde_pkg::PORT_E_DIR_ADDR:  rdata_d = port_e_dir_q;
        default:                        rdata_d = gpio_cde_pkg::READ_ZERO;
      endcase
    end
  end

  // Data latches are not reset.
  always_ff @(posedge mclk_in) begin
    if (wr_c_data) port_c_latch_q <= wdata_in[PORT_C_W-1:0];
    if (wr_d_data) port_d_latch_q <= wdata_in & gpio_cde_pkg::PORT_D_DIR_MASK;
    if (wr_e_data) port_e_latch_q <= wdata_in;
  end

  // Direction registers clear on reset.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      port_c_dir_q <= gpio_cde_pkg::DIR_RESET;
      port_d_dir_q <= gpio_cde_pkg::DIR_RESET;
      port_e_dir_q <= gpio_cde_pkg::DIR_RESET;
    end else begin
      if (wr_c_dir) port_c_dir_q <= wdata_in & gpio_cde_pkg::PORT_C_DIR_MASK;
      if (wr_d_dir) port_d_dir_q <= wdata_in & gpio_cde_pkg::PORT_D_DIR_MASK;
      if (wr_e_dir) port_e_dir_q <= wdata_in;
    end
  end

  // Read data stand for one cycle after the strobe and are zero otherwise.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_out <= gpio_cde_pkg::READ_ZERO;
    end else begin
      rdata_out <= rdata_d;
    end
  end

  // Port C drive, including the clock output toggle.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      clk_half_q        <= 1'b0;
      port_c_pin_out    <= '0;
      port_c_pin_oe_out <= '0;
    end else begin
      clk_half_q        <= !clk_half_q;
      port_c_pin_out    <= c_val;
      port_c_pin_oe_out <= c_oe;
    end
  end

  // Port D drive and the timer clock taken from its pin.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      port_d_pin_out      <= '0;
      port_d_pin_oe_out   <= '0;
      timer_ext_clock_out <= 1'b0;
      port_d_sync_out     <= '0;
    end else begin
      port_d_pin_out      <= port_d_latch_q;
      port_d_pin_oe_out   <= d_oe;
      timer_ext_clock_out <= timer_clk_own & d_sync[gpio_cde_pkg::TIMER_CLK_PIN];
      port_d_sync_out     <= d_sync;
    end
  end

  // Port E drive and the synchronised levels for the sharing peripherals.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      port_e_pin_out    <= '0;
      port_e_pin_oe_out <= '0;
      port_e_sync_out   <= '0;
    end else begin
      port_e_pin_out    <= e_val;
      port_e_pin_oe_out <= e_oe;
      port_e_sync_out   <= e_sync;
    end
  end

  // Assertions.
  dir_reset_a: assert property (@(posedge mclk_in) reset_in |=>
    (port_c_dir_q == 8'h00 && port_d_dir_q == 8'h00 && port_e_dir_q == 8'h00))
    else $error("direction not cleared by reset");
  latch_write_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    wr_e_data |=> port_e_latch_q == $past(wdata_in))
    else $error("port E latch missed a write");
  read_blend_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    rd_in && addr_in == gpio_cde_pkg::PORT_E_DATA_ADDR |=>
    rdata_out == $past((port_e_dir_q & port_e_latch_q) | (~port_e_dir_q & e_sync)))
    else $error("port E read not blended by direction");
  d_bit2_in_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !port_d_pin_oe_out[2])
    else $error("port D bit 2 driven");
  clk_pin_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_out_en && !$past(reset_in) |=> port_c_pin_oe_out[gpio_cde_pkg::CLK_OUT_PIN])
    else $error("clock output pin not enabled");
  gp_drive_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !spi_on && !async_on && !tch0_on && !tch1_on |=> port_e_pin_oe_out == $past(port_e_dir_q))
    else $error("free port E pins not following direction");
  async_own_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    async_on |=> port_e_pin_oe_out[gpio_cde_pkg::ASYNC_TX_PIN]
    && !port_e_pin_oe_out[gpio_cde_pkg::ASYNC_RX_PIN])
    else $error("async serial pins not owned");
  ss_slave_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    spi_on && !master |=> !port_e_pin_oe_out[gpio_cde_pkg::SPI_SS_PIN])
    else $error("slave select driven in slave mode");
  adc_read_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    rd_in && addr_in == gpio_cde_pkg::PORT_D_DATA_ADDR && adc_on_d
    && !port_d_dir_q[adc_rel[2:0]] |=> !rdata_out[$past(adc_rel[2:0])])
    else $error("analog pin read not zero");
  c_latch_write_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    wr_c_data |=> port_c_latch_q == $past(wdata_in[PORT_C_W-1:0]))
    else $error("port C latch missed a write");
  d_latch_write_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    wr_d_data |=> port_d_latch_q == $past(wdata_in & gpio_cde_pkg::PORT_D_DIR_MASK))
    else $error("port D latch missed a write");
  c_oe_dir_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !clk_out_en |=> port_c_pin_oe_out == $past(c_dir))
    else $error("port C enables not following direction");
  d_read_dir_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    rd_in && addr_in == gpio_cde_pkg::PORT_D_DATA_ADDR && !adc_on_d |=>
    rdata_out == $past(blend(port_d_dir_q, port_d_latch_q, d_sync)))
    else $error("port D read not blended by direction");
  c_read_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    rd_in && addr_in == gpio_cde_pkg::PORT_C_DATA_ADDR |=>
    rdata_out == $past(c_read & gpio_cde_pkg::PORT_C_DATA_MASK))
    else $error("port C read wrong");
  idle_read_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !rd_in |=> rdata_out == gpio_cde_pkg::READ_ZERO)
    else $error("read data not zero between reads");
  adc_float_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    adc_on_d |=> (port_d_pin_oe_out & $past(adc_own)) == '0)
    else $error("analog pin driven");
  timer_pin_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    timer_clk_own |=> !port_d_pin_oe_out[gpio_cde_pkg::TIMER_CLK_PIN])
    else $error("timer clock pin driven");
  timer_clk_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !timer_clk_own |=> !timer_ext_clock_out)
    else $error("timer clock passed while not selected");
  spi_master_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    spi_on && master |=> port_e_pin_oe_out[gpio_cde_pkg::SPI_SCK_PIN]
    && port_e_pin_oe_out[gpio_cde_pkg::SPI_MOSI_PIN])
    else $error("SPI master outputs not driven");
  spi_slave_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    spi_on && !master |=> !port_e_pin_oe_out[gpio_cde_pkg::SPI_SCK_PIN]
    && port_e_pin_oe_out[gpio_cde_pkg::SPI_MISO_PIN])
    else $error("SPI slave pins in wrong direction");
  mosi_value_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    spi_on |=> port_e_pin_out[gpio_cde_pkg::SPI_MOSI_PIN] == $past(spi_mosi_val_in))
    else $error("MOSI value not passed");
  tx_value_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    async_on |=> port_e_pin_out[gpio_cde_pkg::ASYNC_TX_PIN] == $past(async_tx_val_in))
    else $error("transmit value not passed");
  timer_drive_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    tch0_on |=> port_e_pin_oe_out[gpio_cde_pkg::TIMER_CH0_PIN] == $past(timer_ch_oe_in[0]))
    else $error("timer channel enable not passed");
  spi_master_c: cover property (@(posedge mclk_in) spi_on && master);
  clk_out_c:    cover property (@(posedge mclk_in) clk_out_en);
  adc_sel_c:    cover property (@(posedge mclk_in) adc_on_d && rd_in);
  spi_slave_c:  cover property (@(posedge mclk_in) spi_on && !master);
  timer_ch_c:   cover property (@(posedge mclk_in) tch0_on && timer_ch_oe_in[0]);

endmodule

// *** dv/board_pins.sv ***
// Board side of one port: resolves the design's drive against the external source.
`timescale 1ns/1ps
module board_pins #(
  parameter int W = 8
) (
  // Design drive
  input  wire logic [W-1:0] pin_val_in,
  input  wire logic [W-1:0] pin_oe_in,
  // External source on every pin
  input  wire logic [W-1:0] ext_in,
  // Resolved wire level
  output logic      [W-1:0] level_out
);
  // A pin the design releases shows the board source, never the last driven value.
  assign level_out = (pin_oe_in & pin_val_in) | (~pin_oe_in & ext_in);
endmodule

// *** dv/gpio_ports_c_d_e_test.sv ***
// Self-checking bench for the port C, D and E block.
`timescale 1ns/1ps
module gpio_ports_c_d_e_test;
  localparam logic [7:0] CDAT = gpio_cde_pkg::PORT_C_DATA_ADDR;
  localparam logic [7:0] DDAT = gpio_cde_pkg::PORT_D_DATA_ADDR;
  localparam logic [7:0] EDAT = gpio_cde_pkg::PORT_E_DATA_ADDR;
  localparam logic [7:0] CDIR = gpio_cde_pkg::PORT_C_DIR_ADDR;
  localparam logic [7:0] DDIR = gpio_cde_pkg::PORT_D_DIR_ADDR;
  localparam logic [7:0] EDIR = gpio_cde_pkg::PORT_E_DIR_ADDR;
  logic       mclk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic       wr_in = 1'b0, rd_in = 1'b0;
  logic [5:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe_out, c_ext = 6'h00;
  logic [7:0] port_d_pin_in, port_d_pin_out, port_d_pin_oe_out, d_ext = 8'h00;
  logic [7:0] port_e_pin_in, port_e_pin_out, port_e_pin_oe_out, e_ext = 8'h3C;
  logic [4:0] adc_channel_select_in = 5'h00;
  logic       adc_active_in = 1'b0, timer_ext_clock_sel_in = 1'b0, timer_ext_clock_out;
  logic [1:0] edge_level_select0_in = 2'h0, edge_level_select1_in = 2'h0;
  logic [1:0] timer_ch_val_in = 2'h0, timer_ch_oe_in = 2'h0;
  logic       serial_periph_enable_in = 1'b0, serial_periph_master_in = 1'b0;
  logic       mode_fault_enable_in = 1'b0, spi_sck_val_in = 1'b0;
  logic       spi_mosi_val_in = 1'b0, spi_miso_val_in = 1'b0;
  logic       async_serial_enable_in = 1'b0, async_tx_val_in = 1'b0;
  logic [7:0] port_e_sync_out, port_d_sync_out;
  int         fail_count = 0;
  int         total_checks = 0;
  logic       ck;

  always #5 mclk_in = ~mclk_in;

  gpio_ports_c_d_e DUT (
    .mclk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .port_c_pin_in, .port_c_pin_out, .port_c_pin_oe_out,
    .port_d_pin_in, .port_d_pin_out, .port_d_pin_oe_out,
    .port_e_pin_in, .port_e_pin_out, .port_e_pin_oe_out,
    .adc_channel_select_in, .adc_active_in, .timer_ext_clock_sel_in, .timer_ext_clock_out,
    .edge_level_select0_in, .edge_level_select1_in, .timer_ch_val_in, .timer_ch_oe_in,
    .serial_periph_enable_in, .serial_periph_master_in, .mode_fault_enable_in,
    .spi_sck_val_in, .spi_mosi_val_in, .spi_miso_val_in,
    .async_serial_enable_in, .async_tx_val_in, .port_e_sync_out, .port_d_sync_out
  );
  board_pins #(.W(6)) board_c (.pin_val_in(port_c_pin_out), .pin_oe_in(port_c_pin_oe_out),
    .ext_in(c_ext), .level_out(port_c_pin_in));
  board_pins #(.W(8)) board_d (.pin_val_in(port_d_pin_out), .pin_oe_in(port_d_pin_oe_out),
    .ext_in(d_ext), .level_out(port_d_pin_in));
  board_pins #(.W(8)) board_e (.pin_val_in(port_e_pin_out), .pin_oe_in(port_e_pin_oe_out),
    .ext_in(e_ext), .level_out(port_e_pin_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 check(rdata_out, exp);
    @(posedge mclk_in);
  endtask
  task automatic pulse_reset;
    reset_in <= 1'b1;
    cyc(2);
    reset_in <= 1'b0;
    cyc(1);
  endtask

  task automatic t_reset;
    rdchk(CDIR, 8'h00);
    rdchk(DDIR, 8'h00);
    rdchk(EDIR, 8'h00);
    check({2'b00, port_c_pin_oe_out} | port_d_pin_oe_out | port_e_pin_oe_out, 8'h00);
    rdchk(8'h05, 8'h00);
  endtask
  task automatic t_port_e;
    wr(EDAT, 8'hA5);
    wr(EDIR, 8'hF0);
    cyc(2);
    check(port_e_pin_oe_out, 8'hF0);
    check(port_e_pin_out & 8'hF0, 8'hA0);
    rdchk(EDAT, 8'hAC);
    wr(EDAT, 8'h5A);
    cyc(3);
    rdchk(EDAT, 8'h5C);
    check(port_e_sync_out, 8'h5C);
    wr(EDIR, 8'hFF);
    rdchk(EDAT, 8'h5A);
  endtask
  task automatic t_port_c;
    wr(CDAT, 8'h2A);
    pulse_reset();
    wr(CDIR, 8'h3F);
    rdchk(CDAT, 8'h2A);
    wr(CDIR, 8'hFB);
    rdchk(CDIR, 8'hBB);
    cyc(2);
    check({2'b00, port_c_pin_oe_out} & 8'h04, 8'h04);
    ck = port_c_pin_out[2];
    cyc(1);
    check({7'h00, port_c_pin_out[2]}, {7'h00, ~ck});
    pulse_reset();
    rdchk(CDIR, 8'h00);
  endtask
  task automatic t_port_d;
    d_ext <= 8'h04;
    wr(DDAT, 8'hFF);
    wr(DDIR, 8'hFF);
    cyc(2);
    rdchk(DDIR, 8'hFB);
    check(port_d_pin_oe_out, 8'hFB);
    rdchk(DDAT, 8'hFF);
    d_ext <= 8'h08;
    wr(DDIR, 8'hF3);
    adc_channel_select_in <= 5'h0B;
    adc_active_in <= 1'b1;
    cyc(4);
    rdchk(DDAT, 8'hF3);
    adc_channel_select_in <= 5'h09;
    cyc(2);
    check(port_d_pin_oe_out & 8'h02, 8'h00);
    rdchk(DDAT, 8'hFB);
    adc_active_in <= 1'b0;
    timer_ext_clock_sel_in <= 1'b1;
    d_ext <= 8'h40;
    cyc(4);
    check({7'h00, timer_ext_clock_out}, 8'h01);
    check(port_d_sync_out & 8'h40, 8'h40);
    d_ext <= 8'h00;
    cyc(4);
    check({7'h00, timer_ext_clock_out}, 8'h00);
    check(port_d_sync_out & 8'h40, 8'h00);
  endtask
  task automatic t_periph;
    wr(EDIR, 8'h30);
    serial_periph_enable_in <= 1'b1;
    serial_periph_master_in <= 1'b1;
    spi_sck_val_in <= 1'b1;
    cyc(3);
    check(port_e_pin_out & 8'hC0, 8'h80);
    check(port_e_pin_oe_out & 8'hD0, 8'hD0);
    serial_periph_master_in <= 1'b0;
    spi_miso_val_in <= 1'b1;
    cyc(3);
    check(port_e_pin_oe_out & 8'hB0, 8'h20);
    check(port_e_pin_out & 8'h20, 8'h20);
    rdchk(EDAT, 8'h1C);
    serial_periph_enable_in <= 1'b0;
    async_serial_enable_in <= 1'b1;
    async_tx_val_in <= 1'b1;
    edge_level_select0_in <= 2'h1;
    cyc(3);
    check(port_e_pin_out & 8'hF0, 8'h50);
    check(port_e_pin_out & 8'h01, 8'h01);
    check(port_e_pin_oe_out & 8'hF7, 8'h31);
    timer_ch_oe_in <= 2'h1;
    timer_ch_val_in <= 2'h1;
    cyc(3);
    check(port_e_pin_oe_out & 8'h04, 8'h04);
    check(port_e_pin_out & 8'h04, 8'h04);
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    cyc(6);
    reset_in <= 1'b0;
    cyc(1);
    t_reset();
    t_port_e();
    t_port_c();
    t_port_d();
    t_periph();
    finish_test();
  end
  initial begin
    #50us;
    fail_count++;
    finish_test();
  end
endmodule
